// ---- rtl/tecc_pkg.sv ----
// Purpose: Constants, register map and carrier types of the timer/event counter.
// Assumes: AXI4-Lite register bus with 32-bit data, byte addresses below.
// Notes:   Narrow fields sit in the low bits; upper bits read as zero.
package tecc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OFS_TIMER_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_PRESCALER     = 8'h04;
	localparam logic [7:0]  OFS_CC_CTRL       = 8'h08;
	localparam logic [7:0]  OFS_EDGE_MODE     = 8'h0c;
	localparam logic [7:0]  OFS_SAMPLE_SEL    = 8'h10;
	localparam logic [7:0]  OFS_COMPARE_A     = 8'h14;
	localparam logic [7:0]  OFS_CAPTURE_CMP   = 8'h18;
	localparam logic [7:0]  OFS_COUNTER       = 8'h1c;
	localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h20;
	localparam logic [7:0]  OFS_IRQ_MASK      = 8'h24;

	// ****************************************
	// Field encodings and reset values
	// ****************************************
	localparam logic [3:0]  PRESC_EXT         = 4'hf;
	localparam logic [3:0]  PRESC_MAX_SEL     = 4'h8;
	localparam int          PRESC_BASE_SHIFT  = 2;
	localparam logic [1:0]  EDGE_FALL         = 2'h0;
	localparam logic [1:0]  EDGE_RISE         = 2'h1;
	localparam logic [1:0]  EDGE_BOTH         = 2'h2;
	localparam int          FILTER_LEN        = 3;
	localparam int          IRQ_BIT_A         = 0;
	localparam int          IRQ_BIT_B         = 1;
	localparam int          IRQ_BIT_EDGE      = 2;
	localparam logic [15:0] MASK_8BIT         = 16'h00ff;
	localparam logic [15:0] MASK_16BIT        = 16'hffff;
	localparam logic [15:0] COUNT_RESET       = 16'h0000;
	localparam logic [3:0]  PRESC_RESET       = 4'h0;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic output_mode;
		logic width16;
		logic count_en;
	} tecc_tctrl_t;

	typedef struct packed {
		logic clr_capture;
		logic cc_capture;
		logic clr_b;
		logic clr_a;
	} tecc_ccc_t;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_ARM  = 3'b010,
		ST_RUN  = 3'b100
	} tecc_state_t;
endpackage

// ---- rtl/tecc_timer.sv ----
// Purpose: Up-counting timer/event counter with two compare channels and capture.
// Assumes: Single clock aclk; capture_edge_input is asynchronous to it.
// Notes:   Registers are reached over AXI4-Lite; one interrupt output.
//
// What this block does
// - Clear-on-match compare gives period n plus one.
// - Count clock is main clock over 4..1024.
// - Input phases under three samples are ignored.
// - Each valid edge while armed or running copies counter into capture register.
// - Stopping on a match still raises match request.
// - First count clock after start only arms counting.
// - Compare write suppresses that channel's match.
// - Matches are evaluated only on counter increments and on stopping.
// - Event counter reads zero after one edge.
// - Enable set or cleared zeroes counter; repeat ignored.
// - Compare match raises request, optionally clears counter.
// - Edge mode selects trigger; capture may clear counter.
`timescale 1ns/1ns
module tecc_timer #(
	parameter int DIV_W = 10
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        capture_edge_input,
	output logic             irq
);
	import tecc_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************
	// Merges written bytes into a 32-bit value under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// True once every 2**sh cycles of the free-running divider.
	function automatic logic div_tick(input logic [DIV_W-1:0] div, input int sh);
		logic [DIV_W-1:0] m;
		m = DIV_W'((1 << sh) - 1);
		return (div & m) == m;
	endfunction

	// Any offset that maps onto a register.
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= OFS_IRQ_MASK;
	endfunction

	// ****************************************
	// State declarations
	// ****************************************
	logic              aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0]        awaddr_reg, awaddr_next, araddr_ok;
	logic [31:0]       wdata_reg, wdata_next;
	logic [3:0]        wstrb_reg, wstrb_next;
	logic              awready_reg, awready_next, wready_reg, wready_next;
	logic              bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic              rvalid_reg, rvalid_next;
	logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]       rdata_reg, rdata_next, rd_value;
	logic              wr_fire;
	logic              sync1_reg, sync2_reg;
	logic [FILTER_LEN-1:0] hist_reg, hist_next;
	logic              level_reg, level_next, rise, fall, edge_valid, samp_tick;
	logic [DIV_W-1:0]  div_reg, div_next;
	tecc_tctrl_t       tctrl_reg, tctrl_next;
	tecc_ccc_t         ccc_reg, ccc_next;
	logic [3:0]        presc_reg, presc_next;
	logic [1:0]        edge_mode_reg, edge_mode_next, samp_sel_reg, samp_sel_next;
	logic [15:0]       cmp_a_reg, cmp_a_next, cc_reg, cc_next, cnt_reg, cnt_next;
	logic [2:0]        status_reg, status_next, mask_reg, mask_next;
	logic              irq_reg, irq_next;
	tecc_state_t       state_reg, state_next;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign irq           = irq_reg;
	assign araddr_ok     = s_axi_araddr;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// Read mux; a read has no side effect on any register.
	always_comb begin
		rd_value = 32'h0000_0000;
		if (araddr_ok == OFS_TIMER_CTRL) begin
			rd_value = {29'h0, tctrl_reg};
		end else if (araddr_ok == OFS_PRESCALER) begin
			rd_value = {28'h0, presc_reg};
		end else if (araddr_ok == OFS_CC_CTRL) begin
			rd_value = {28'h0, ccc_reg};
		end else if (araddr_ok == OFS_EDGE_MODE) begin
			rd_value = {30'h0, edge_mode_reg};
		end else if (araddr_ok == OFS_SAMPLE_SEL) begin
			rd_value = {30'h0, samp_sel_reg};
		end else if (araddr_ok == OFS_COMPARE_A) begin
			rd_value = {16'h0, cmp_a_reg};
		end else if (araddr_ok == OFS_CAPTURE_CMP) begin
			rd_value = {16'h0, cc_reg};
		end else if (araddr_ok == OFS_COUNTER) begin
			rd_value = {16'h0, cnt_reg};
		end else if (araddr_ok == OFS_IRQ_STATUS) begin
			rd_value = {29'h0, status_reg};
		end else if (araddr_ok == OFS_IRQ_MASK) begin
			rd_value = {29'h0, mask_reg};
		end
	end

	// Address and data are held separately, so they may arrive in either order.
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		arready_next = arready_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		wr_fire      = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_held_reg && w_held_reg && !bvalid_reg) begin
			wr_fire      = mapped(awaddr_reg);
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next  = 1'b1;
			rdata_next   = rd_value;
			rresp_next   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next  = 1'b0;
			arready_next = 1'b1;
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next  = !w_held_next && !bvalid_next;
		// Reopen the read slot when neither a request nor read data is pending.
		if (!arready_reg && !rvalid_reg) begin
			arready_next = 1'b1;
		end
	end

	// Bus handshake registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ****************************************
	// Input sampling and edge filter
	// ****************************************
	// The divider runs free, so a restart may see a partial first period.
	always_comb begin
		div_next  = div_reg + DIV_W'(1);
		samp_tick = 1'b1;
		case (samp_sel_reg)
			2'h1:    samp_tick = div_tick(div_reg, 5);
			2'h2:    samp_tick = div_tick(div_reg, 6);
			2'h3:    samp_tick = div_tick(div_reg, 7);
			default: samp_tick = 1'b1;
		endcase
		hist_next  = hist_reg;
		level_next = level_reg;
		if (samp_tick) begin
			hist_next = {hist_reg[FILTER_LEN-2:0], sync2_reg};
			if (&hist_next) begin
				level_next = 1'b1;
			end else if (~|hist_next) begin
				level_next = 1'b0;
			end
		end
		rise       = level_next && !level_reg;
		fall       = !level_next && level_reg;
		edge_valid = (edge_mode_reg == EDGE_RISE && rise) ||
		             (edge_mode_reg == EDGE_FALL && fall) ||
		             (edge_mode_reg == EDGE_BOTH && (rise || fall));
	end

	// Two-flop synchroniser, sample history and filtered level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			hist_reg  <= '0;
			level_reg <= 1'b0;
			div_reg   <= '0;
		end else begin
			sync1_reg <= capture_edge_input;
			sync2_reg <= sync1_reg;
			hist_reg  <= hist_next;
			level_reg <= level_next;
			div_reg   <= div_next;
		end
	end

	// ****************************************
	// Timer core and registers
	// ****************************************
	logic        cnt_tick, wr_a, wr_cc, cmp_b_on, clr_now, ce_new;
	logic [15:0] wmask, inc_val;
	logic [31:0] wval;

	always_comb begin
		tctrl_next     = tctrl_reg;
		ccc_next       = ccc_reg;
		presc_next     = presc_reg;
		edge_mode_next = edge_mode_reg;
		samp_sel_next  = samp_sel_reg;
		cmp_a_next     = cmp_a_reg;
		cc_next        = cc_reg;
		cnt_next       = cnt_reg;
		mask_next      = mask_reg;
		status_next    = status_reg;
		state_next     = state_reg;
		wval           = 32'h0000_0000;
		wr_a           = 1'b0;
		wr_cc          = 1'b0;
		wmask          = tctrl_reg.width16 ? MASK_16BIT : MASK_8BIT;
		cmp_b_on       = !ccc_reg.cc_capture;
		// Internal count clock is a power-of-two division of the main clock.
		cnt_tick = div_tick(div_reg, PRESC_BASE_SHIFT + int'(presc_reg));
		if (presc_reg == PRESC_EXT) begin
			cnt_tick = edge_valid;
		end else if (presc_reg > PRESC_MAX_SEL) begin
			cnt_tick = div_tick(div_reg, PRESC_BASE_SHIFT + int'(PRESC_MAX_SEL));
		end
		// Software writes; mode fields change regardless of the running count.
		if (wr_fire) begin
			if (awaddr_reg == OFS_TIMER_CTRL) begin
				wval       = merge({29'h0, tctrl_reg}, wdata_reg, wstrb_reg);
				tctrl_next = tecc_tctrl_t'(wval[2:0]);
			end else if (awaddr_reg == OFS_PRESCALER) begin
				wval       = merge({28'h0, presc_reg}, wdata_reg, wstrb_reg);
				presc_next = wval[3:0];
			end else if (awaddr_reg == OFS_CC_CTRL) begin
				wval     = merge({28'h0, ccc_reg}, wdata_reg, wstrb_reg);
				ccc_next = tecc_ccc_t'(wval[3:0]);
			end else if (awaddr_reg == OFS_EDGE_MODE) begin
				wval           = merge({30'h0, edge_mode_reg}, wdata_reg, wstrb_reg);
				edge_mode_next = wval[1:0];
			end else if (awaddr_reg == OFS_SAMPLE_SEL) begin
				wval          = merge({30'h0, samp_sel_reg}, wdata_reg, wstrb_reg);
				samp_sel_next = wval[1:0];
			end else if (awaddr_reg == OFS_COMPARE_A) begin
				wval       = merge({16'h0, cmp_a_reg}, wdata_reg, wstrb_reg);
				cmp_a_next = wval[15:0];
				wr_a       = 1'b1;
			end else if (awaddr_reg == OFS_CAPTURE_CMP) begin
				wval    = merge({16'h0, cc_reg}, wdata_reg, wstrb_reg);
				cc_next = wval[15:0];
				wr_cc   = 1'b1;
			end else if (awaddr_reg == OFS_IRQ_STATUS) begin
				wval        = merge(32'h0, wdata_reg, wstrb_reg);
				status_next = status_reg & ~wval[2:0];
			end else if (awaddr_reg == OFS_IRQ_MASK) begin
				wval      = merge({29'h0, mask_reg}, wdata_reg, wstrb_reg);
				mask_next = wval[2:0];
			end
		end
		ce_new  = tctrl_next.count_en;
		clr_now = (ccc_reg.clr_a && cnt_reg == (cmp_a_reg & wmask)) ||
		          (cmp_b_on && ccc_reg.clr_b && cnt_reg == (cc_reg & wmask));
		inc_val = clr_now ? COUNT_RESET : ((cnt_reg + 16'h0001) & wmask);
		case (state_reg)
			ST_STOP: begin
				if (ce_new) begin
					state_next = ST_ARM;
					cnt_next   = COUNT_RESET;
				end
			end
			ST_ARM: begin
				if (!ce_new) begin
					state_next = ST_STOP;
				end else if (cnt_tick) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ce_new) begin
					state_next = ST_STOP;
				end else if (cnt_tick) begin
					cnt_next = inc_val;
					// Matches only on an increment, and never against a compare being written.
					if (!wr_a && inc_val == (cmp_a_reg & wmask)) begin
						status_next[IRQ_BIT_A] = 1'b1;
					end
					if (cmp_b_on && !wr_cc && inc_val == (cc_reg & wmask)) begin
						status_next[IRQ_BIT_B] = 1'b1;
					end
				end
			end
			default: state_next = ST_STOP;
		endcase
		if (!ce_new) begin
			cnt_next = COUNT_RESET;
			// Stopping while armed or running on a compare value still raises its request.
			if (state_reg != ST_STOP && !wr_a && cnt_reg == (cmp_a_reg & wmask)) begin
				status_next[IRQ_BIT_A] = 1'b1;
			end
			if (state_reg != ST_STOP && cmp_b_on && !wr_cc && cnt_reg == (cc_reg & wmask)) begin
				status_next[IRQ_BIT_B] = 1'b1;
			end
		end
		// Capture overrides a software write to the same register in that cycle.
		if (edge_valid) begin
			status_next[IRQ_BIT_EDGE] = 1'b1;
			if (ccc_reg.cc_capture && state_reg != ST_STOP && ce_new) begin
				cc_next = cnt_reg & wmask;
				if (ccc_reg.clr_capture) begin
					cnt_next = COUNT_RESET;
				end
			end
		end
		irq_next = |(status_next & mask_next);
	end

	// Core registers; flags set by events win over a same-cycle clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tctrl_reg     <= '0;
			ccc_reg       <= '0;
			presc_reg     <= PRESC_RESET;
			edge_mode_reg <= EDGE_FALL;
			samp_sel_reg  <= 2'h0;
			cmp_a_reg     <= COUNT_RESET;
			cc_reg        <= COUNT_RESET;
			cnt_reg       <= COUNT_RESET;
			status_reg    <= 3'h0;
			mask_reg      <= 3'h0;
			irq_reg       <= 1'b0;
			state_reg     <= ST_STOP;
		end else begin
			tctrl_reg     <= tctrl_next;
			ccc_reg       <= ccc_next;
			presc_reg     <= presc_next;
			edge_mode_reg <= edge_mode_next;
			samp_sel_reg  <= samp_sel_next;
			cmp_a_reg     <= cmp_a_next;
			cc_reg        <= cc_next;
			cnt_reg       <= cnt_next;
			status_reg    <= status_next;
			mask_reg      <= mask_next;
			irq_reg       <= irq_next;
			state_reg     <= state_next;
		end
	end
endmodule

// ---- testbench/tecc_timer_properties.sv ----
// Purpose: Port-level protocol checks for the timer register slave.
// Assumes: One clock domain; aresetn synchronous and active low.
// Notes:   Only the top ports are seen; timer internals are judged by the bench.
`timescale 1ns/1ns
module tecc_timer_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	// ****************************************
	// Clocking, sequences and assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A write is taken when both address and data handshake together.
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence s_b_reopen;
		!s_axi_bvalid ##1 s_axi_awready;
	endsequence

	a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not seen two cycles after handshake");
	a_write_reopen: assert property (s_b_done |=> s_b_reopen)
		else $error("write slot did not reopen after response");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed before bready");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while a response is pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not valid one cycle after address");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed before rready");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data is pending");
	a_read_reopen: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read slot did not reopen after data");
	// Outputs must leave reset quiet, the stopped timer raising nothing.
	a_reset_quiet: assert property ($rose(aresetn) |->
		!irq && !s_axi_awready && !s_axi_bvalid)
		else $error("outputs active at first edge after reset");
endmodule

bind tecc_timer tecc_timer_properties u_tecc_timer_properties (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ---- testbench/tecc_pulse_src.sv ----
// Purpose: External pulse source on the capture pin.
// Assumes: Pulses are whole aclk cycles long; the pin idles low.
// Notes:   One high pulse of the requested width per fire request.
`timescale 1ns/1ns
module tecc_pulse_src (
	input  wire logic        aclk,
	input  wire logic        fire,
	input  wire logic [15:0] width,
	output logic             capture_edge_input
);
	// ****************************************
	// Pulse generator
	// ****************************************
	int left;

	initial begin
		capture_edge_input = 1'b0;
		left = 0;
	end

	// Short widths are allowed on purpose so the input filter can be probed.
	always @(posedge aclk) begin
		if (fire) begin
			capture_edge_input <= 1'b1;
			left <= int'(width) - 1;
		end else if (left > 0) begin
			left <= left - 1;
		end else begin
			capture_edge_input <= 1'b0;
		end
	end
endmodule

// ---- testbench/tecc_timer_tb_top.sv ----
// Purpose: Self-checking bench for the timer through its register bus.
// Assumes: Software stops the counter before rewriting mode registers.
// Notes:   The measured pulse width is a multiple of the divide-by-four count clock.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin miscompares++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module tecc_timer_tb_top;
	import tecc_pkg::*;
	// ****************************************
	// Signals, clock and instances
	// ****************************************
	logic        aclk, aresetn, fire, capture_edge_input, irq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, d0;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] pulse_width;
	int          miscompares, samples_checked, cyc, t_first, sel;

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	tecc_timer u_tecc_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .capture_edge_input(capture_edge_input), .irq(irq));
	tecc_pulse_src u_tecc_pulse_src (.aclk(aclk), .fire(fire), .width(pulse_width),
		.capture_edge_input(capture_edge_input));

	// ****************************************
	// Bus tasks and closing
	// ****************************************
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic give_up;
		$display("wrong value wait expected done seen timeout");
		miscompares++;
		end_of_test();
	endtask

	// Handshakes are judged at the falling edge, which sees what the next rise samples.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hit, w_hit, b_hit;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge aclk);
			aw_hit = s_axi_awvalid && s_axi_awready;
			w_hit = s_axi_wvalid && s_axi_wready;
			b_hit = s_axi_bvalid;
			if (b_hit) resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_hit) s_axi_awvalid <= 1'b0;
			if (w_hit) s_axi_wvalid <= 1'b0;
			if (b_hit) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar_hit, r_hit;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge aclk);
			ar_hit = s_axi_arvalid && s_axi_arready;
			r_hit = s_axi_rvalid;
			if (r_hit) rd_data = s_axi_rdata;
			if (r_hit) resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_hit) s_axi_arvalid <= 1'b0;
			if (r_hit) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	task automatic wait_irq;
		for (int n = 0; n < 20000; n++) begin
			@(negedge aclk);
			if (irq === 1'b1) return;
		end
		give_up();
	endtask
	task automatic pulse(input logic [15:0] w);
		@(posedge aclk);
		pulse_width <= w;
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge aclk);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{aresetn, fire, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		pulse_width = 16'h0000;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_COUNTER);
		`CHK("counter", {16'h0000, COUNT_RESET}, rd_data);
		rd(OFS_EDGE_MODE);
		`CHK("edge mode", {30'h0, EDGE_FALL}, rd_data);
		rd(8'h40);
		`CHK("unmapped read", {RESP_SLVERR, 32'h0}, {resp, rd_data});
		wr(8'h40, 32'h1);
		`CHK("unmapped write", RESP_SLVERR, resp);
		// Compare on the capture/compare register clears the counter every n plus one ticks.
		for (sel = 0; sel <= 8; sel++) begin
			wr(OFS_CC_CTRL, 32'h2);
			wr(OFS_CAPTURE_CMP, 32'h3);
			wr(OFS_PRESCALER, sel);
			wr(OFS_IRQ_MASK, 32'h2);
			wr(OFS_TIMER_CTRL, 32'h1);
			wait_irq();
			t_first = cyc;
			wr(OFS_IRQ_STATUS, 32'h2);
			wait_irq();
			`CHK("period", (3 + 1) * (1 << (sel + 2)), cyc - t_first);
			wr(OFS_IRQ_MASK, 32'h0);
			wr(OFS_TIMER_CTRL, 32'h0);
			wr(OFS_IRQ_STATUS, 32'h7);
		end
		// External mode with no edges keeps the count at zero with no ticks at all.
		wr(OFS_CC_CTRL, 32'h0);
		wr(OFS_PRESCALER, {28'h0, PRESC_EXT});
		wr(OFS_COMPARE_A, 32'h5);
		wr(OFS_TIMER_CTRL, 32'h1);
		wr(OFS_COMPARE_A, 32'h0);
		rd(OFS_IRQ_STATUS);
		`CHK("no match on write", 1'b0, rd_data[IRQ_BIT_A]);
		wr(OFS_TIMER_CTRL, 32'h0);
		rd(OFS_IRQ_STATUS);
		`CHK("match on stop", 1'b1, rd_data[IRQ_BIT_A]);
		`CHK("irq masked", 1'b0, irq);
		wr(OFS_IRQ_MASK, 32'h1);
		idle(2);
		`CHK("irq unmasked", 1'b1, irq);
		wr(OFS_IRQ_STATUS, 32'h1);
		idle(2);
		`CHK("irq cleared", 1'b0, irq);
		// Start, restart while running, and stop of the internal count.
		wr(OFS_PRESCALER, 32'h0);
		wr(OFS_TIMER_CTRL, 32'h1);
		idle(50);
		rd(OFS_COUNTER);
		d0 = rd_data[7:0];
		`CHK("running", 1'b1, rd_data != 32'h0);
		// The new compare lies far from both the old value and the running count.
		wr(OFS_COMPARE_A, 32'h80);
		wr(OFS_TIMER_CTRL, 32'h1);
		rd(OFS_COUNTER);
		`CHK("no restart", 1'b1, rd_data[7:0] > d0);
		wr(OFS_TIMER_CTRL, 32'h0);
		rd(OFS_COUNTER);
		`CHK("stopped", 32'h0, rd_data);
		// Pulse-width capture on both edges, sampling every clock.
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_SAMPLE_SEL, 32'h0);
		wr(OFS_EDGE_MODE, {30'h0, EDGE_BOTH});
		wr(OFS_CC_CTRL, 32'h4);
		wr(OFS_TIMER_CTRL, 32'h1);
		pulse(16'd2);
		idle(20);
		rd(OFS_IRQ_STATUS);
		`CHK("glitch ignored", 1'b0, rd_data[IRQ_BIT_EDGE]);
		pulse(16'd40);
		idle(15);
		rd(OFS_IRQ_STATUS);
		`CHK("edge flag", 1'b1, rd_data[IRQ_BIT_EDGE]);
		rd(OFS_CAPTURE_CMP);
		d0 = rd_data[7:0];
		idle(40);
		rd(OFS_CAPTURE_CMP);
		`CHK("width", 8'd10, rd_data[7:0] - d0);
		// External events: the first edge only arms the counter.
		wr(OFS_TIMER_CTRL, 32'h0);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_EDGE_MODE, {30'h0, EDGE_RISE});
		wr(OFS_CC_CTRL, 32'h0);
		wr(OFS_PRESCALER, {28'h0, PRESC_EXT});
		wr(OFS_TIMER_CTRL, 32'h1);
		pulse(16'd10);
		idle(30);
		rd(OFS_COUNTER);
		`CHK("one event", 32'h0, rd_data);
		rd(OFS_IRQ_STATUS);
		`CHK("event flag", 1'b1, rd_data[IRQ_BIT_EDGE]);
		pulse(16'd10);
		idle(30);
		rd(OFS_COUNTER);
		`CHK("two events", 32'h1, rd_data);
		end_of_test();
	end
endmodule
